// ### flash_ctl_pkg.sv
// Constants and types of the flash command controller
//
// Overview of operation
// - Host reads both identifier codes, address bit 0 at 0 then 1.
// - Program is setup write 40H or 10H, then a write of address and data.
// - Block erase is 20H then D0H, both writes addressed inside the block.
// - Command 70H at any address selects status read mode.
// - FFH, 50H, B0H and D0H resume are single writes with address ignored.
package flash_ctl_pkg;

  // ==========================================================================
  // Device command codes (low data byte)
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_IDENT        = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
  localparam logic [7:0] CMD_PROG_ALT     = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND      = 8'hB0;

  // ==========================================================================
  // Device status register bit positions
  localparam int SR_READY    = 7;
  localparam int SR_SUSPEND  = 6;
  localparam int SR_ERASE_ER = 5;
  localparam int SR_PROG_ER  = 4;
  localparam int SR_VPP      = 3;

  // ==========================================================================
  // APB register offsets of the controller
  localparam logic [7:0] REG_CMD    = 8'h00; // RW: op code, a write while not busy starts a job, a read returns the last op
  localparam logic [7:0] REG_ADDR   = 8'h04; // RW: device address
  localparam logic [7:0] REG_WDATA  = 8'h08; // RW: write data
  localparam logic [7:0] REG_RDATA  = 8'h0C; // RO: data of the last two reads, newest in the low half
  localparam logic [7:0] REG_STATE  = 8'h10; // RO: busy, last status
  localparam logic [7:0] REG_IRQ    = 8'h14; // W1C: event flags
  localparam logic [7:0] REG_MASK   = 8'h18; // RW: interrupt mask

  // Controller operation codes written to REG_CMD
  localparam logic [2:0] OP_RAW_WRITE = 3'h0; // one command write
  localparam logic [2:0] OP_READ      = 3'h1; // one bus read
  localparam logic [2:0] OP_PROGRAM   = 3'h2; // setup + data, poll ready
  localparam logic [2:0] OP_ERASE     = 3'h3; // setup + confirm, poll ready
  localparam logic [2:0] OP_IDENT     = 3'h4; // 90H, two reads
  localparam logic [2:0] OP_CLEAR     = 3'h5; // 50H
  localparam logic [2:0] OP_SUSPEND   = 3'h6; // B0H, poll ready
  localparam logic [2:0] OP_RESUME    = 3'h7; // D0H

  // Interrupt flag positions
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_ERROR = 1;
  localparam int IRQ_W     = 2;

  // ==========================================================================
  // Device bus timing: each strobe phase in cycles of 4 ns
  localparam int STROBE_NS  = 80;
  localparam int CLK_NS     = 4;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_VALUE = 0;
  // Extra read cycles so the data has crossed the synchroniser
  localparam int READ_SETTLE = 4;

  // Device pin group
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] dq_out;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
  } dev_pins_t;

endpackage

// ### flash_ctl_sync.sv
// Three-stage input synchroniser for device data pins
`timescale 1ns/1ps
module flash_ctl_sync #(
  parameter int W = 16
) (
  input  wire logic         CORE_CLK,
  input  wire logic         RSTN,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  // ==========================================================================
  // Value taken once second and third stage agree, so one-cycle glitches never pass
  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3)
      st_nxt.q = st_r.s3;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign dout = st_r.q;

endmodule

// ### flash_ctl.sv
// Host-side controller driving the flash command interface from APB
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module flash_ctl #(
  parameter int STROBE = flash_ctl_pkg::STROBE_CYC
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  input  wire logic [7:0]  PADDR,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             IRQ,
  output logic [19:0]      DEV_ADDR,
  output logic [15:0]      DEV_DQ_OUT,
  output logic             DEV_DQ_OE,
  input  wire logic [15:0] DEV_DQ_IN,
  output logic             DEV_CE_N,
  output logic             DEV_OE_N,
  output logic             DEV_WE_N
);

  typedef enum logic [3:0] {
    S_IDLE, S_W_SETUP, S_W_PULSE, S_W_HOLD,
    S_R_PULSE, S_R_WAIT, S_STEP
  } state_t;

  typedef struct packed {
    state_t                  state;
    logic [2:0]              op;
    logic [2:0]              step;
    logic [7:0]              cnt;
    logic [19:0]             addr;
    logic [15:0]             wdata;
    logic [31:0]             rdata;
    logic [7:0]              status;
    logic                    busy;
    logic [flash_ctl_pkg::IRQ_W-1:0] irq;
    logic [flash_ctl_pkg::IRQ_W-1:0] mask;
    flash_ctl_pkg::dev_pins_t pins;
  } ctl_t;

  ctl_t        st_r;
  ctl_t        st_nxt;
  logic [15:0] dq_sync;
  logic        bus_wr;
  logic        bus_rd;

  flash_ctl_sync #(.W(16)) u_sync (
    .CORE_CLK (CORE_CLK),
    .RSTN     (RSTN),
    .din      (DEV_DQ_IN),
    .dout     (dq_sync)
  );

  // Start one device write cycle of the given data at the given address
  function automatic ctl_t do_write(ctl_t s, logic [19:0] a, logic [15:0] d);
    ctl_t r;
    r              = s;
    r.pins.addr    = a;
    r.pins.dq_out  = d;
    r.pins.dq_oe   = 1'b1;
    r.pins.ce_n    = 1'b0;
    r.cnt          = 8'(STROBE);
    r.state        = S_W_SETUP;
    return r;
  endfunction

  // Start one device read cycle
  function automatic ctl_t do_read(ctl_t s, logic [19:0] a);
    ctl_t r;
    r             = s;
    r.pins.addr   = a;
    r.pins.dq_oe  = 1'b0;
    r.pins.ce_n   = 1'b0;
    r.pins.oe_n   = 1'b0;
    r.cnt         = 8'(STROBE);
    r.state       = S_R_PULSE;
    return r;
  endfunction

  // Command word: upper byte driven high, device decodes the low byte only
  function automatic logic [15:0] cmd_word(logic [7:0] c);
    return {8'hFF, c};
  endfunction

  assign bus_wr = PSEL && PENABLE && PWRITE;
  assign bus_rd = PSEL && !PWRITE;

  // ==========================================================================
  // APB read mux; zero-wait slave
  always_comb
  begin
    PRDATA = 32'h0000_0000;
    case (PADDR)
      flash_ctl_pkg::REG_ADDR:  PRDATA = {12'h000, st_r.addr};
      flash_ctl_pkg::REG_WDATA: PRDATA = {16'h0000, st_r.wdata};
      flash_ctl_pkg::REG_RDATA: PRDATA = st_r.rdata;
      flash_ctl_pkg::REG_STATE: PRDATA = {23'h0, st_r.busy, st_r.status};
      flash_ctl_pkg::REG_IRQ:   PRDATA = {30'h0, st_r.irq};
      flash_ctl_pkg::REG_MASK:  PRDATA = {30'h0, st_r.mask};
      flash_ctl_pkg::REG_CMD:   PRDATA = {29'h0, st_r.op};
      default:                  PRDATA = 32'h0000_0000;
    endcase
    if (!bus_rd)
      PRDATA = 32'h0000_0000;
  end

  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && (PADDR[1:0] != 2'b00 || PADDR > 8'h18);

  // ==========================================================================
  // Command sequencer and register updates
  always_comb
  begin
    st_nxt = st_r;
    // Software register writes; a new job is refused while busy
    if (bus_wr)
    begin
      case (PADDR)
        flash_ctl_pkg::REG_ADDR:  st_nxt.addr = PWDATA[19:0];
        flash_ctl_pkg::REG_WDATA: st_nxt.wdata = PWDATA[15:0];
        flash_ctl_pkg::REG_MASK:  st_nxt.mask = PWDATA[1:0];
        flash_ctl_pkg::REG_IRQ:   st_nxt.irq = st_r.irq & ~PWDATA[1:0];
        flash_ctl_pkg::REG_CMD:
          if (!st_r.busy)
          begin
            st_nxt.op   = PWDATA[2:0];
            st_nxt.step = 3'h0;
            st_nxt.busy = 1'b1;
            st_nxt.state = S_STEP;
          end
        default: ;
      endcase
    end
    case (st_r.state)
      S_IDLE: ;
      // Each job is a short script of device cycles selected by step
      S_STEP:
      begin
        st_nxt.step = st_r.step + 3'h1;
        case (st_r.op)
          flash_ctl_pkg::OP_RAW_WRITE:
            if (st_r.step == 3'h0)
              st_nxt = do_write(st_nxt, st_r.addr, cmd_word(st_r.wdata[7:0]));
            else
              st_nxt.busy = 1'b0;
          flash_ctl_pkg::OP_READ:
            if (st_r.step == 3'h0)
              st_nxt = do_read(st_nxt, st_r.addr);
            else
              st_nxt.busy = 1'b0;
          flash_ctl_pkg::OP_PROGRAM, flash_ctl_pkg::OP_ERASE:
            case (st_r.step)
              3'h0:
                st_nxt = do_write(st_nxt, st_r.addr, cmd_word(
                  st_r.op == flash_ctl_pkg::OP_PROGRAM ?
                  flash_ctl_pkg::CMD_PROG_SETUP :
                  flash_ctl_pkg::CMD_ERASE_SETUP));
              3'h1:
                st_nxt = do_write(st_nxt, st_r.addr,
                  st_r.op == flash_ctl_pkg::OP_PROGRAM ? st_r.wdata :
                  cmd_word(flash_ctl_pkg::CMD_CONFIRM));
              // Device drops into status mode itself; just poll reads
              3'h2: st_nxt = do_read(st_nxt, st_r.addr);
              default:
                // Poll until ready, only then are error flags valid
                if (!st_r.status[flash_ctl_pkg::SR_READY])
                begin
                  st_nxt = do_read(st_nxt, st_r.addr);
                  st_nxt.step = 3'h3;
                end
                else
                  st_nxt.busy = 1'b0;
            endcase
          flash_ctl_pkg::OP_IDENT:
            case (st_r.step)
              3'h0: st_nxt = do_write(st_nxt, st_r.addr,
                      cmd_word(flash_ctl_pkg::CMD_IDENT));
              3'h1: st_nxt = do_read(st_nxt, 20'h00000);
              3'h2: st_nxt = do_read(st_nxt, 20'h00001);
              default: st_nxt.busy = 1'b0;
            endcase
          flash_ctl_pkg::OP_CLEAR:
            // Command 50H, sent here or by a raw write, is the only way to drop accumulated error flags
            if (st_r.step == 3'h0)
              st_nxt = do_write(st_nxt, st_r.addr,
                cmd_word(flash_ctl_pkg::CMD_CLEAR_STATUS));
            else
              st_nxt.busy = 1'b0;
          flash_ctl_pkg::OP_SUSPEND:
            case (st_r.step)
              3'h0: st_nxt = do_write(st_nxt, st_r.addr,
                      cmd_word(flash_ctl_pkg::CMD_SUSPEND));
              3'h1: st_nxt = do_write(st_nxt, st_r.addr,
                      cmd_word(flash_ctl_pkg::CMD_READ_STATUS));
              3'h2: st_nxt = do_read(st_nxt, st_r.addr);
              default:
                // Ready with suspend flag marks a reached suspension
                if (!st_r.status[flash_ctl_pkg::SR_READY])
                begin
                  st_nxt = do_read(st_nxt, st_r.addr);
                  st_nxt.step = 3'h3;
                end
                else
                  st_nxt.busy = 1'b0;
            endcase
          flash_ctl_pkg::OP_RESUME:
            // Only resume, read-array or read-status reach a suspended erase
            if (st_r.step == 3'h0)
              st_nxt = do_write(st_nxt, st_r.addr,
                cmd_word(flash_ctl_pkg::CMD_CONFIRM));
            else
              st_nxt.busy = 1'b0;
          default: st_nxt.busy = 1'b0;
        endcase
        if (!st_nxt.busy)
        begin
          st_nxt.state = S_IDLE;
          st_nxt.irq[flash_ctl_pkg::IRQ_DONE] = 1'b1;
          // Error flags are sticky in the device over a run
          if (st_r.status[flash_ctl_pkg::SR_ERASE_ER] ||
              st_r.status[flash_ctl_pkg::SR_PROG_ER] ||
              st_r.status[flash_ctl_pkg::SR_VPP])
            st_nxt.irq[flash_ctl_pkg::IRQ_ERROR] = 1'b1;
        end
      end
      // Address and data settle before the write strobe
      S_W_SETUP:
      begin
        st_nxt.pins.we_n = 1'b0;
        st_nxt.cnt       = 8'(STROBE);
        st_nxt.state     = S_W_PULSE;
      end
      S_W_PULSE:
        if (st_r.cnt != 8'h00)
          st_nxt.cnt = st_r.cnt - 8'h01;
        else
        begin
          st_nxt.pins.we_n = 1'b1; // Device latches on this rising edge
          st_nxt.cnt       = 8'(STROBE);
          st_nxt.state     = S_W_HOLD;
        end
      S_W_HOLD:
        if (st_r.cnt != 8'h00)
          st_nxt.cnt = st_r.cnt - 8'h01;
        else
        begin
          st_nxt.pins.ce_n  = 1'b1;
          st_nxt.pins.dq_oe = 1'b0;
          st_nxt.state      = S_STEP;
        end
      // Access time plus synchroniser latency before sampling
      S_R_PULSE:
        if (st_r.cnt != 8'h00)
          st_nxt.cnt = st_r.cnt - 8'h01;
        else
        begin
          st_nxt.cnt   = 8'(flash_ctl_pkg::READ_SETTLE);
          st_nxt.state = S_R_WAIT;
        end
      S_R_WAIT:
        if (st_r.cnt != 8'h00)
          st_nxt.cnt = st_r.cnt - 8'h01;
        else
        begin
          st_nxt.rdata  = {st_r.rdata[15:0], dq_sync};
          st_nxt.status = dq_sync[7:0];
          st_nxt.pins.oe_n = 1'b1;
          st_nxt.pins.ce_n = 1'b1;
          st_nxt.state     = S_STEP;
        end
      default: st_nxt.state = S_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      st_r           <= '0;
      st_r.state     <= S_IDLE;
      st_r.pins.ce_n <= 1'b1;
      st_r.pins.oe_n <= 1'b1;
      st_r.pins.we_n <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // ==========================================================================
  // Pin outputs straight from flip-flops, interrupt as the OR of the masked flags
  assign IRQ        = |(st_r.irq & st_r.mask);
  assign DEV_ADDR   = st_r.pins.addr;
  assign DEV_DQ_OUT = st_r.pins.dq_out;
  assign DEV_DQ_OE  = st_r.pins.dq_oe;
  assign DEV_CE_N   = st_r.pins.ce_n;
  assign DEV_OE_N   = st_r.pins.oe_n;
  assign DEV_WE_N   = st_r.pins.we_n;

endmodule

// ### flash_ctl_assertions.sv
// Port checks of the flash controller
`timescale 1ns/1ps
module flash_ctl_checker #(
  parameter int STROBE = 2
) (
  input wire logic        CORE_CLK,
  input wire logic        RSTN,
  input wire logic [7:0]  PADDR,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        IRQ,
  input wire logic [19:0] DEV_ADDR,
  input wire logic [15:0] DEV_DQ_OUT,
  input wire logic        DEV_DQ_OE,
  input wire logic        DEV_CE_N,
  input wire logic        DEV_OE_N,
  input wire logic        DEV_WE_N
);
  int we_cnt_r;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);

  // ==========================================================================
  // Write strobe low time, checked at its rise
  always_ff @(posedge CORE_CLK)
    if (!RSTN || DEV_WE_N)
      we_cnt_r <= 0;
    else
      we_cnt_r <= we_cnt_r + 1;

  // ==========================================================================
  // Device bus
  AST_WE_FRAMED: assert property (!DEV_WE_N |->
    !DEV_CE_N && DEV_DQ_OE && DEV_OE_N) else $error("Stray write strobe");
  AST_CE_LEADS: assert property ($fell(DEV_CE_N) |->
    DEV_WE_N && DEV_OE_N == DEV_DQ_OE) else $error("Strobe with select");
  AST_WE_WIDTH: assert property ($rose(DEV_WE_N) |->
    we_cnt_r == STROBE + 1) else $error("Write strobe width");
  AST_WE_HOLD: assert property ($rose(DEV_WE_N) |-> !DEV_CE_N &&
    $stable(DEV_ADDR) && $stable(DEV_DQ_OUT)) else $error("No hold");
  AST_WE_STABLE: assert property ($fell(DEV_WE_N) |=>
    $stable(DEV_DQ_OUT)[*2]) else $error("Data moved in write");
  AST_READ_FREE: assert property (!DEV_OE_N |->
    !DEV_DQ_OE && !DEV_CE_N && DEV_WE_N) else $error("Read clash");
  AST_RESET_IDLE: assert property ($rose(RSTN) |-> DEV_CE_N &&
    DEV_WE_N && DEV_OE_N && !DEV_DQ_OE && !IRQ) else $error("Not idle");

  // ==========================================================================
  // Register bus
  AST_READY: assert property (PSEL && PENABLE |-> PREADY)
    else $error("Wait state");
  AST_WR_QUIET: assert property (PSEL && PWRITE |-> PRDATA == 32'h0)
    else $error("Read data on write");
  AST_UNMAPPED: assert property (PSEL && PENABLE && PADDR > 8'h18 |->
    PSLVERR && PRDATA == 32'h0) else $error("Unmapped accepted");

  CV_WRITE: cover property ($rose(DEV_WE_N));
  CV_READ: cover property ($fell(DEV_OE_N));
  CV_IRQ: cover property ($rose(IRQ));
endmodule

bind flash_ctl flash_ctl_checker #(.STROBE(STROBE)) i_chk (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .PADDR(PADDR), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .IRQ(IRQ), .DEV_ADDR(DEV_ADDR),
  .DEV_DQ_OUT(DEV_DQ_OUT), .DEV_DQ_OE(DEV_DQ_OE), .DEV_CE_N(DEV_CE_N),
  .DEV_OE_N(DEV_OE_N), .DEV_WE_N(DEV_WE_N));

// ### flash_dev_model.sv
// Behavioural flash device: command decoder, status and array
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [15:0] MAKER = 16'h0001, // Arbitrary value
  parameter logic [15:0] DEVID = 16'h0002  // Arbitrary value
) (
  input  wire logic [19:0] addr,
  input  wire logic [15:0] dq,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        fail_prog,
  output logic      [15:0] dq_in
);
  logic [15:0] mem [logic [19:0]];
  logic [1:0]  mode = 2'h0; // 0 array, 1 status, 2 identifier
  logic [1:0]  pend = 2'h0; // 1 data due, 2 confirm due
  logic [1:0]  err  = 2'h0; // Erase and program error flags
  logic        susp = 1'h0;
  logic        ers  = 1'h0;
  int          busy = 0; // Status reads left before ready
  logic [15:0] word;
  logic [15:0] hold = 16'h0;
  logic [7:0]  c;

  // ==========================================================================
  // Commands taken on the rising write strobe
  always @(posedge we_n)
    if (!ce_n)
    begin
      c = dq[7:0];
      if (pend != 2'h0)
      begin
        if (pend == 2'h1)
        begin
          mem[addr] = dq;
          err[0] = err[0] | fail_prog;
          busy = 3;
        end
        else if (c == 8'hD0)
        begin
          foreach (mem[k])
            if (k[19:12] == addr[19:12])
              mem[k] = 16'hFFFF;
          ers = 1'h1;
          busy = 3;
        end
        else
          err = 2'h3;
        mode = 2'h1;
        pend = 2'h0;
      end
      else if (!susp || c inside {8'hFF, 8'h70, 8'hD0})
        case (c)
          8'hFF: mode = 2'h0;
          8'h70: mode = 2'h1;
          8'h90: mode = 2'h2;
          8'h50: err = 2'h0;
          8'h40, 8'h10: pend = 2'h1;
          8'h20: pend = 2'h2;
          8'hB0: susp = ers;
          8'hD0: if (susp)
          begin
            susp = 1'h0;
            busy = 3;
          end
          default: ;
        endcase
    end

  // ==========================================================================
  // Read path; a released bus shows the inverse of the last word
  always @*
  begin
    if (mode == 2'h1)
      word = {8'h00, busy == 0, susp, err, 4'h0};
    else if (mode == 2'h2)
      word = addr[0] ? DEVID : MAKER;
    else
      word = mem.exists(addr) ? mem[addr] : 16'hFFFF;
    dq_in = (ce_n || oe_n) ? ~hold : word;
  end

  // Each status read lets the sequencer move on; this makes it slow.
  // Chip select rises with the output strobe, so it is not looked at here
  always @(posedge oe_n)
    begin
      hold = word;
      if (mode == 2'h1 && busy > 0)
        busy--;
      if (busy == 0 && !susp)
        ers = 1'h0;
    end
endmodule

// ### tb.sv
// Testbench of the flash controller against the device model
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] MAKER = 16'h00C3; // Arbitrary value
  localparam logic [15:0] DEVID = 16'h5A17; // Arbitrary value
  logic        CORE_CLK  = 1'h0;
  logic        RSTN      = 1'h0;
  logic [7:0]  PADDR     = 8'h00;
  logic        PSEL      = 1'h0;
  logic        PENABLE   = 1'h0;
  logic        PWRITE    = 1'h0;
  logic [31:0] PWDATA    = 32'h0;
  logic        fail_prog = 1'h0;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, IRQ, DEV_DQ_OE, DEV_CE_N, DEV_OE_N, DEV_WE_N;
  logic [19:0] DEV_ADDR;
  logic [15:0] DEV_DQ_OUT, DEV_DQ_IN;
  logic [31:0] q;
  logic        se;
  int          err_count = 0;
  int          comparisons = 0;

  // ==========================================================================
  // Clock, design and device
  always #2 CORE_CLK = ~CORE_CLK;

  flash_ctl #(.STROBE(2)) i_dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
    .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .IRQ(IRQ), .DEV_ADDR(DEV_ADDR), .DEV_DQ_OUT(DEV_DQ_OUT),
    .DEV_DQ_OE(DEV_DQ_OE), .DEV_DQ_IN(DEV_DQ_IN), .DEV_CE_N(DEV_CE_N),
    .DEV_OE_N(DEV_OE_N), .DEV_WE_N(DEV_WE_N));

  flash_dev_model #(.MAKER(MAKER), .DEVID(DEVID)) i_dev (.addr(DEV_ADDR),
    .dq(DEV_DQ_OUT), .ce_n(DEV_CE_N), .oe_n(DEV_OE_N), .we_n(DEV_WE_N),
    .fail_prog(fail_prog), .dq_in(DEV_DQ_IN));

  // ==========================================================================
  // Tasks
  task automatic end_of_test;
    $display("Comparisons %0d, errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; answer taken at the edge that samples PREADY high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'h1;
    do
    begin
      @(posedge CORE_CLK);
      n++;
    end
    while (PREADY !== 1'h1 && n < 100);
    q = PRDATA;
    se = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    if (n >= 100)
    begin
      err_count++;
      end_of_test();
    end
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'h0, a, 32'h0);
  endtask

  // Address, data, then the job; busy is polled with a bound
  task automatic job(input logic [2:0] op, input logic [19:0] a,
                     input logic [15:0] d);
    int n;
    n = 0;
    apb(1'h1, flash_ctl_pkg::REG_ADDR, {12'h000, a});
    apb(1'h1, flash_ctl_pkg::REG_WDATA, {16'h0000, d});
    apb(1'h1, flash_ctl_pkg::REG_CMD, {29'h0, op});
    do
    begin
      rd(flash_ctl_pkg::REG_STATE);
      n++;
    end
    while (q[8] !== 1'h0 && n < 500);
    if (n >= 500)
    begin
      err_count++;
      end_of_test();
    end
  endtask

  task automatic stat(input logic [7:0] e);
    rd(flash_ctl_pkg::REG_STATE);
    chk(q & 32'h1FF, {24'h0, e});
  endtask

  task automatic rstat(input logic [7:0] e);
    job(flash_ctl_pkg::OP_READ, 20'h3FFFF, 16'h0);
    stat(e);
  endtask

  task automatic rarr(input logic [19:0] a, input logic [15:0] e);
    job(flash_ctl_pkg::OP_RAW_WRITE, 20'h0, 16'h00FF);
    job(flash_ctl_pkg::OP_READ, a, 16'h0);
    rd(flash_ctl_pkg::REG_RDATA);
    chk(q & 32'hFFFF, {16'h0, e});
  endtask

  // ==========================================================================
  // Sequence
  initial
  begin
    repeat (4) @(posedge CORE_CLK);
    RSTN <= 1'h1;
    rd(flash_ctl_pkg::REG_MASK);
    chk(q, 32'h0);
    rd(8'h1C);
    chk({31'h0, se}, 32'h1);
    rd(8'h12);
    chk({31'h0, se}, 32'h1);
    job(flash_ctl_pkg::OP_IDENT, 20'hABCD2, 16'h0);
    rd(flash_ctl_pkg::REG_RDATA);
    chk(q, {MAKER, DEVID});
    fail_prog <= 1'h1;
    job(flash_ctl_pkg::OP_PROGRAM, 20'h00101, 16'h5678);
    fail_prog <= 1'h0;
    job(flash_ctl_pkg::OP_PROGRAM, 20'h00102, 16'h1111);
    stat(8'h90);
    rarr(20'h00101, 16'h5678);
    job(flash_ctl_pkg::OP_RAW_WRITE, 20'h00200, 16'h0010);
    job(flash_ctl_pkg::OP_RAW_WRITE, 20'h00200, 16'h00AB);
    // Raw program is not polled; status reads let it finish first
    repeat (3) job(flash_ctl_pkg::OP_READ, 20'h0, 16'h0);
    rarr(20'h00200, 16'hFFAB);
    job(flash_ctl_pkg::OP_RAW_WRITE, 20'h0, 16'h0070);
    rstat(8'h90);
    job(flash_ctl_pkg::OP_CLEAR, 20'h0, 16'h0);
    job(flash_ctl_pkg::OP_RAW_WRITE, 20'h0, 16'h0070);
    rstat(8'h80);
    job(flash_ctl_pkg::OP_RAW_WRITE, 20'h0, 16'h0020);
    job(flash_ctl_pkg::OP_RAW_WRITE, 20'h0, 16'h00FF);
    rstat(8'hB0);
    rarr(20'h00101, 16'h5678);
    job(flash_ctl_pkg::OP_CLEAR, 20'h0, 16'h0);
    job(flash_ctl_pkg::OP_ERASE, 20'h00155, 16'h0);
    stat(8'h80);
    rarr(20'h00101, 16'hFFFF);
    job(flash_ctl_pkg::OP_RAW_WRITE, 20'h0, 16'h0020);
    job(flash_ctl_pkg::OP_RAW_WRITE, 20'h0, 16'h00D0);
    job(flash_ctl_pkg::OP_SUSPEND, 20'h0, 16'h0);
    stat(8'hC0);
    job(flash_ctl_pkg::OP_RAW_WRITE, 20'h0, 16'h0090);
    rstat(8'hC0);
    job(flash_ctl_pkg::OP_RESUME, 20'h0, 16'h0);
    repeat (3) job(flash_ctl_pkg::OP_READ, 20'h0, 16'h0);
    rstat(8'h80);
    chk({31'h0, IRQ}, 32'h0);
    apb(1'h1, flash_ctl_pkg::REG_MASK, 32'h3);
    rd(flash_ctl_pkg::REG_IRQ);
    chk(q, 32'h3);
    chk({31'h0, IRQ}, 32'h1);
    apb(1'h1, flash_ctl_pkg::REG_IRQ, 32'h3);
    rd(flash_ctl_pkg::REG_IRQ);
    chk(q, 32'h0);
    chk({31'h0, IRQ}, 32'h0);
    end_of_test();
  end

  // Watchdog against a hang
  initial
  begin
    repeat (100000) @(posedge CORE_CLK);
    err_count++;
    end_of_test();
  end
endmodule
